/* core/bps_pkg.sv */
package bps_pkg;
   // timing, in cycles of the 125 MHz system clock
   localparam int unsigned BPS_CLK_HZ = 125_000_000;
   localparam int unsigned BPS_PROG_MS = 5;
   localparam int unsigned BPS_PROG_CYCLES = BPS_CLK_HZ / 1000 * BPS_PROG_MS;
   localparam int unsigned BPS_SW_HZ = 600_000;
   localparam int unsigned BPS_SW_DIV = BPS_CLK_HZ / BPS_SW_HZ;
   localparam int unsigned BPS_SS_US = 4500;
   localparam int unsigned BPS_SS_CYCLES = BPS_CLK_HZ / 1000 * BPS_SS_US / 1000;
   // threshold codes in millivolts
   localparam int unsigned BPS_TH_W = 10;
   localparam logic [9:0] BPS_TH_MIN_MV = 10'h032;
   localparam logic [9:0] BPS_TH_MAX_MV = 10'h226;
   localparam logic [9:0] BPS_CLAMP_MV = 10'h258;
   localparam logic [9:0] BPS_TH_RST = 10'h000;
   localparam logic [2:0] BPS_OC_RUN = 3'h4;

   typedef enum logic [2:0] {
      BPS_ST_PROG = 3'b000,
      BPS_ST_SOFT = 3'b001,
      BPS_ST_RUN = 3'b010,
      BPS_ST_OFF = 3'b011,
      BPS_ST_OVER = 3'b100
   } bps_state_t;

   // comparator decisions on the output-sense input
   typedef struct packed {
      logic above_ov;
      logic above_half;
      logic below_uv;
      logic in_window;
   } bps_sense_t;

   // gate commands to the power stage
   typedef struct packed {
      logic high_on;
      logic low_on;
      logic low_free;
   } bps_gate_t;
endpackage : bps_pkg

/* core/bps_sync.sv */
module bps_sync
   import bps_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // two flops; only the second stage is read outside
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : bps_sync

/* core/bps_supervisor.sv */
// Function
// - After lockout release a 5 ms programming phase sources the test current out of the low-side gate pin.
// - At the end of programming the gate-pin voltage is sampled and held as the first-level threshold.
// - The held first-level threshold spans 50 mV to 550 mV.
// - The second-level threshold is the held first level times 1.5.
// - A gate-pin voltage of 600 mV clamps, selects maximum thresholds and ends programming at once.
// - Leaving the power-good window drops the power-good flag while switching continues.
// - The power-good flag is first raised when soft-start completes.
// - Undervoltage turns both switches off in a latch released only by a power cycle.
// - Overvoltage above about 1 V turns the high side off, the low side on, and latches.
// - In overvoltage the low side turns off once the sense falls below 0.4 V.
// - While overvoltage is latched the low side turns on again above 0.4 V.
// - The sense pin bias pulls an open pin high so it is handled as overvoltage.
// - Undervoltage is ignored during soft-start; other protections act throughout.
// - Soft-start begins only after lockout release and completed programming.
// - Overcurrent trips after four consecutive first-level cycles or at once on second level.
// - An overcurrent trip turns both switches off and latches until a power cycle.
module bps_supervisor
   import bps_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = BPS_PROG_CYCLES,
   parameter int unsigned SS_CYCLES = BPS_SS_CYCLES,
   parameter int unsigned SW_DIV = BPS_SW_DIV
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [9:0] gate_pin_mv,
   input wire logic [3:0] sense_raw,
   input wire logic [9:0] phase_drop_mv,
   input wire logic pwm_req,
   output logic limit_program_current,
   output logic power_ok_flag,
   output logic high_side_switch,
   output logic low_side_switch,
   output logic overcurrent_trip,
   output logic undervoltage_trip,
   output logic overvoltage_trip,
   output logic soft_start_active,
   output logic [9:0] level1_mv,
   output logic [10:0] level2_mv
);
   // counters are 23 and 8 bits wide; refuse counts they cannot hold
   if (PROG_CYCLES < 32'h0000_0002 || PROG_CYCLES > 32'h0080_0000 ||
       SS_CYCLES < 32'h0000_0002 || SS_CYCLES > 32'h0080_0000 ||
       SW_DIV < 32'h0000_0002 || SW_DIV > 32'h0000_0100) begin : g_bad
      $error("bps_supervisor: counts out of range");
   end

   //////////////////////////////////////////////////////////////////////
   // synchronise comparator decisions from the analog side
   bps_sense_t sense;
   logic [3:0] sense_s;
   logic [9:0] gate_s;
   logic [9:0] phase_s;
   logic pwm_s;

   bps_sync #(.WIDTH(25)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({sense_raw, gate_pin_mv, phase_drop_mv, pwm_req}),
      .sync_out({sense_s, gate_s, phase_s, pwm_s})
   );
   assign sense = bps_sense_t'(sense_s);

   //////////////////////////////////////////////////////////////////////
   // state and counters
   bps_state_t state_q, state_d;
   logic [22:0] cnt_q;
   logic [7:0] sw_q;
   logic [2:0] oc_run_q;
   logic oc_seen_q;
   logic [9:0] th1_q;
   logic [9:0] gate_prev_q;
   logic [9:0] phase_prev_q;
   logic [2:0] ls_hist_q;

   //////////////////////////////////////////////////////////////////////
   // pin words pass the two flops bit by bit and may arrive torn;
   // trust a word only when two samples in a row agree
   wire gate_steady = (gate_s == gate_prev_q);
   wire phase_steady = (phase_s == phase_prev_q);
   // phase drop means nothing unless the low side was on for both samples
   wire ls_settled = low_side_switch && (&ls_hist_q);

   wire sw_tick = (sw_q == 8'(SW_DIV - 1));
   // a torn sample at the deadline only stretches programming two cycles
   wire prog_done = (cnt_q >= 23'(PROG_CYCLES - 1)) && gate_steady;
   wire ss_done = (cnt_q == 23'(SS_CYCLES - 1));
   wire clamp_hit = gate_steady && (gate_s >= BPS_CLAMP_MV);
   // sample clipped into the programmable span
   wire [9:0] sample_mv = (gate_s < BPS_TH_MIN_MV) ? BPS_TH_MIN_MV :
                          (gate_s > BPS_TH_MAX_MV) ? BPS_TH_MAX_MV :
                          gate_s;
   wire take_clamp = (state_q == BPS_ST_PROG) && clamp_hit;
   wire take_sample = (state_q == BPS_ST_PROG) && prog_done;
   // next threshold, so the outputs change with soft-start, not after it
   wire [9:0] th1_d = take_clamp ? BPS_TH_MAX_MV :
                      take_sample ? sample_mv : th1_q;
   wire [10:0] th2_d = 11'({1'b0, th1_d}) + 11'(th1_d >> 1);
   wire [10:0] th2 = 11'({1'b0, th1_q}) + 11'(th1_q >> 1);
   wire lvl1 = ls_settled && phase_steady &&
               (11'(phase_s) > 11'(th1_q));
   wire lvl2 = ls_settled && phase_steady && (11'(phase_s) > th2);
   wire active = (state_q == BPS_ST_SOFT) || (state_q == BPS_ST_RUN);
   wire oc_trip = active && (lvl2 || (sw_tick && oc_seen_q &&
                  oc_run_q == BPS_OC_RUN - 3'h1));
   // open sense pin reads as above_ov through the bias pull-up
   wire ov_trip = active && sense.above_ov;
   wire uv_trip = (state_q == BPS_ST_RUN) && sense.below_uv;

   // fault priority: overvoltage keeps low-side control, so it wins
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         BPS_ST_PROG: if (prog_done || clamp_hit) state_d = BPS_ST_SOFT;
         BPS_ST_SOFT: begin
            if (ov_trip) state_d = BPS_ST_OVER;
            else if (oc_trip) state_d = BPS_ST_OFF;
            else if (ss_done) state_d = BPS_ST_RUN;
         end
         BPS_ST_RUN: begin
            if (ov_trip) state_d = BPS_ST_OVER;
            else if (oc_trip || uv_trip) state_d = BPS_ST_OFF;
         end
         BPS_ST_OFF: state_d = BPS_ST_OFF;
         BPS_ST_OVER: state_d = BPS_ST_OVER;
         default: state_d = BPS_ST_OFF;
      endcase
   end

   // only the lockout reset leaves the latched states
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= BPS_ST_PROG;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d != state_q) ? 23'h000000 : cnt_q + 23'h000001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sw_q <= '0;
      end else begin
         sw_q <= sw_tick ? 8'h00 : sw_q + 8'h01;
      end
   end

   // first-level events counted per switching cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         oc_seen_q <= 1'b0;
         oc_run_q <= '0;
      end else if (sw_tick) begin
         oc_seen_q <= 1'b0;
         oc_run_q <= oc_seen_q ? oc_run_q + 3'h1 : 3'h0;
      end else if (lvl1) begin
         oc_seen_q <= 1'b1;
      end
   end

   // threshold held until the next lockout reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         th1_q <= BPS_TH_RST;
      end else begin
         th1_q <= th1_d;
      end
   end

   // previous pin words and low-side history for the steadiness checks
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gate_prev_q <= '0;
         phase_prev_q <= '0;
         ls_hist_q <= '0;
      end else begin
         gate_prev_q <= gate_s;
         phase_prev_q <= phase_s;
         ls_hist_q <= {ls_hist_q[1:0], low_side_switch};
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs, all registered
   wire prog_d = (state_d == BPS_ST_PROG);
   wire over_d = (state_d == BPS_ST_OVER);
   // in overvoltage the low side follows the half-reference comparator
   wire ls_d = over_d ? sense.above_half :
               active && (state_d != BPS_ST_OFF) && !pwm_s;
   wire hs_d = active && (state_d == BPS_ST_SOFT ||
               state_d == BPS_ST_RUN) && pwm_s;
   wire pg_seen_d = (state_d == BPS_ST_RUN);
   wire pg_d = pg_seen_d && sense.in_window;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         limit_program_current <= 1'b0;
         power_ok_flag <= 1'b0;
         high_side_switch <= 1'b0;
         low_side_switch <= 1'b0;
         overcurrent_trip <= 1'b0;
         undervoltage_trip <= 1'b0;
         overvoltage_trip <= 1'b0;
         soft_start_active <= 1'b0;
         level1_mv <= BPS_TH_RST;
         level2_mv <= '0;
      end else begin
         limit_program_current <= prog_d && !clamp_hit;
         power_ok_flag <= pg_d;
         high_side_switch <= hs_d;
         low_side_switch <= ls_d;
         overcurrent_trip <= overcurrent_trip ||
                             (oc_trip && state_d == BPS_ST_OFF);
         undervoltage_trip <= undervoltage_trip ||
                              (uv_trip && state_d == BPS_ST_OFF);
         overvoltage_trip <= overvoltage_trip || over_d;
         soft_start_active <= (state_d == BPS_ST_SOFT);
         level1_mv <= th1_d;
         level2_mv <= th2_d;
      end
   end
endmodule : bps_supervisor

/* tb/bps_stage_model.sv */
module bps_stage_model
   import bps_pkg::*;
(
   input wire logic limit_program_current,
   input wire logic low_side_switch,
   input wire logic [9:0] r_mv,
   input wire logic [9:0] drop_mv,
   output logic [9:0] gate_pin_mv,
   output logic [9:0] phase_drop_mv
);
   timeunit 1ns;
   timeprecision 1ps;
   // an open pin climbs until the device clamp holds it
   wire logic [9:0] prog_mv = (r_mv > BPS_CLAMP_MV) ? BPS_CLAMP_MV : r_mv;
   assign gate_pin_mv = limit_program_current ? prog_mv : 10'h000;
   // drop is meaningless with low side off, so show garbage
   assign phase_drop_mv = low_side_switch ? drop_mv : ~drop_mv;
endmodule : bps_stage_model

/* tb/bps_supervisor_asserts.sv */
module bps_supervisor_asserts
   import bps_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] sense_raw,
   input wire logic limit_program_current,
   input wire logic power_ok_flag,
   input wire logic high_side_switch,
   input wire logic low_side_switch,
   input wire logic overcurrent_trip,
   input wire logic undervoltage_trip,
   input wire logic overvoltage_trip,
   input wire logic soft_start_active,
   input wire logic [9:0] level1_mv,
   input wire logic [10:0] level2_mv
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_LVL2: assert property (level2_mv ==
      {1'b0, level1_mv} + {2'h0, level1_mv[9:1]}) else $error("level2");
   AST_RANGE: assert property (soft_start_active |->
      level1_mv inside {[10'h032:10'h226]}) else $error("level1 range");
   AST_OV_STICK: assert property (overvoltage_trip |=>
      overvoltage_trip) else $error("ov dropped");
   AST_UV_STICK: assert property ($rose(undervoltage_trip) |=>
      undervoltage_trip[*8]) else $error("uv dropped");
   AST_OV_HS: assert property (overvoltage_trip |->
      !high_side_switch) else $error("hs on in ov");
   AST_OV_LOW: assert property (overvoltage_trip &&
      $past(overvoltage_trip, 4) |->
      low_side_switch == $past(sense_raw[2], 3)) else $error("ov low");
   AST_OFF: assert property ((undervoltage_trip || overcurrent_trip) &&
      !overvoltage_trip |=> !high_side_switch && !low_side_switch)
      else $error("switch on in trip");
   AST_PG: assert property (soft_start_active || limit_program_current
      |-> !power_ok_flag) else $error("early pg");
   AST_UV_SOFT: assert property (soft_start_active |->
      !undervoltage_trip) else $error("uv in soft");
   AST_PROG: assert property (limit_program_current |->
      !soft_start_active && !low_side_switch) else $error("prog");
   AST_OV_RISE: assert property ((!limit_program_current && sense_raw[3])
      [*4] |=> overvoltage_trip) else $error("ov late");
   cover property (overcurrent_trip);
   cover property ($rose(undervoltage_trip));
   cover property ($fell(low_side_switch) && overvoltage_trip);
endmodule : bps_supervisor_asserts

bind bps_supervisor bps_supervisor_asserts u_bps_asserts (.sys_clk, .rst_n,
   .sense_raw, .limit_program_current, .power_ok_flag, .high_side_switch,
   .low_side_switch, .overcurrent_trip, .undervoltage_trip,
   .overvoltage_trip, .soft_start_active, .level1_mv, .level2_mv);

/* tb/testbench.sv */
module testbench
   import bps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, pwm_req, pc, pg, hs, ls, oc, uv, ov, ss;
   logic [3:0] sense_raw;
   logic [9:0] r_mv, drop_mv, gate_pin_mv, phase_drop_mv, l1;
   logic [10:0] l2;
   int n_errors = 0;
   int num_checks = 0;
   // short counts keep the run small
   bps_supervisor #(.PROG_CYCLES(50), .SS_CYCLES(40), .SW_DIV(8))
   u_bps_supervisor (.sys_clk, .rst_n, .gate_pin_mv, .sense_raw,
      .phase_drop_mv, .pwm_req, .limit_program_current(pc),
      .power_ok_flag(pg), .high_side_switch(hs), .low_side_switch(ls),
      .overcurrent_trip(oc), .undervoltage_trip(uv), .overvoltage_trip(ov),
      .soft_start_active(ss), .level1_mv(l1), .level2_mv(l2));
   bps_stage_model u_bps_stage_model (.limit_program_current(pc),
      .low_side_switch(ls), .r_mv, .drop_mv, .gate_pin_mv, .phase_drop_mv);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   // reset held two cycles; every flop clears synchronously
   task automatic boot(input logic [9:0] r, input logic [3:0] s);
      rst_n = 1'b0;
      r_mv = r;
      sense_raw = s;
      drop_mv = 10'h000;
      pwm_req = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(1);
   endtask : boot
   initial begin
      #40000;
      n_errors++;
      print_verdict();
   end
   initial begin
      boot(10'h12c, 4'h5);
      chk(pc, 1'b1);
      chk(l1, 10'h000);
      cyc(60);
      chk(l1, 10'h12c);
      chk(l2, 11'h1c2);
      chk(pg, 1'b0);
      cyc(50);
      chk(pg, 1'b1);
      sense_raw = 4'h4;
      pwm_req = 1'b1;
      cyc(5);
      chk(pg, 1'b0);
      chk(hs, 1'b1);
      pwm_req = 1'b0;
      drop_mv = 10'h15e;
      cyc(12);
      chk(oc, 1'b0);
      cyc(40);
      chk(oc, 1'b1);
      pwm_req = 1'b1;
      cyc(5);
      chk(hs, 1'b0);
      boot(10'h2bc, 4'h5);
      chk(oc, 1'b0);
      cyc(12);
      chk(ss, 1'b1);
      chk(l2, 11'h339);
      sense_raw = 4'h2;
      cyc(10);
      chk(uv, 1'b0);
      cyc(60);
      chk(uv, 1'b1);
      pwm_req = 1'b1;
      sense_raw = 4'h5;
      cyc(10);
      chk({uv, hs}, 2'h2);
      boot(10'h12c, 4'hc);
      cyc(60);
      chk({ov, ls}, 2'h3);
      pwm_req = 1'b1;
      sense_raw = 4'h0;
      cyc(5);
      chk({ov, hs, ls}, 3'h4);
      sense_raw = 4'h4;
      cyc(5);
      chk(ls, 1'b1);
      boot(10'h12c, 4'h5);
      cyc(120);
      drop_mv = 10'h1f4;
      cyc(5);
      chk(oc, 1'b1);
      print_verdict();
   end
endmodule : testbench
